// ---- include/bfag_consts.vh ----
// Constants for the boot flash access guard
`ifndef BFAG_CONSTS_VH
`define BFAG_CONSTS_VH

// Flash word address and byte address widths
`define BFAG_WA_W 13
`define BFAG_BA_W 14

// First word of the stalling area (fixed split)
`define BFAG_STALL_START 13'h1C00

// Store operation command codes
`define BFAG_CMD_FILL   3'h0
`define BFAG_CMD_ERASE  3'h1
`define BFAG_CMD_WRITE  3'h2
`define BFAG_CMD_LOCK   3'h3
`define BFAG_CMD_REREAD 3'h4

// Lock bit positions inside the 4-bit lock word
`define BFAG_APP_WRITE_BIT 0
`define BFAG_APP_READ_BIT  1
`define BFAG_LDR_WRITE_BIT 2
`define BFAG_LDR_READ_BIT  3

// Lock word with nothing programmed
`define BFAG_LOCK_NONE 4'hF

// Register offsets
`define BFAG_REG_STATUS 4'h0
`define BFAG_REG_CTRL   4'h4

// Status register fields
`define BFAG_ST_BUSY_BIT   0
`define BFAG_ST_ACTIVE_BIT 1
`define BFAG_ST_HALT_BIT   2
`define BFAG_ST_LOCK_LSB   4

// Control register fields and reset value
`define BFAG_CTRL_VEC_BIT 0
`define BFAG_CTRL_RESET   1'h0

`endif

// ---- logic/bfag_lock_decode.v ----
// Decoder for one two-bit boot lock field
`timescale 1ns/1ps

module bfag_lock_decode (
  input  wire [1:0] field,       // {read bit, write bit}, 0 = programmed
  output wire       write_deny,  // Store writes and erases refused
  output wire       read_deny    // Cross-section loads and irqs barred
);

  // Write bit programmed: modes 10 and 00 bar writes
  assign write_deny = ~field[0];

  // Read bit programmed: modes 00 and 01 bar reads
  assign read_deny  = ~field[1];

endmodule // bfag_lock_decode

// ---- logic/bfag_guard.v ----
// Boot flash access guard: stall, busy flag and lock checks
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "bfag_consts.vh"

// Notes on behaviour
// - Stalling area programming halts CPU throughout
// - Concurrent area programming keeps CPU running
// - Two independent lock fields, app and loader
// - Locks only clear on full chip erase
// - General write lock ignores program stores
// - General read/write lock ignores loads, stores
// - Lock bit 1 unprogrammed, 0 programmed
// - App field 11: app section unrestricted
// - App write bit 0: refuse app writes
// - App read bit 0: loader loads of app refused
// - App read bit, loader vectors: mute app irqs
// - Loader field 11: loader section unrestricted
// - Loader write bit 0: refuse loader writes
// - Loader read bit 0: app loads of loader refused
// - Loader read bit, app vectors: mute loader irqs
// - Program stores act only from loader section
// - Busy flag set while concurrent area blocked
module bfag_guard (
  input  wire                  clk,             // System clock
  input  wire                  reset,           // Async, active high
  input  wire [3:0]            reg_addr,        // Register byte offset
  input  wire [7:0]            reg_wdata,       // Register write data
  input  wire                  reg_wr,          // Write strobe
  input  wire                  reg_rd,          // Read strobe
  output wire [7:0]            reg_rdata,       // Read data, next cycle
  input  wire [`BFAG_WA_W-1:0] fetch_addr,      // Word address executing
  input  wire [`BFAG_WA_W-1:0] loader_start,    // First loader word
  input  wire                  irq_req_in,      // Core wants an irq
  output wire                  irq_allow,       // Irq may be taken
  output wire                  fetch_block,     // Fetch must not proceed
  input  wire                  load_req,        // Program memory load
  input  wire [`BFAG_BA_W-1:0] load_addr,       // Load byte address
  output wire                  load_grant,      // Load passed to flash
  input  wire                  store_req,       // Program store op
  input  wire [2:0]            store_cmd,       // Store command code
  input  wire [`BFAG_WA_W-1:0] store_addr,      // Store word address
  input  wire [7:0]            store_data,      // Lock data for lock set
  output wire                  flash_fill,      // Page buffer fill pulse
  output wire                  flash_erase,     // Page erase start pulse
  output wire                  flash_write,     // Page write start pulse
  output wire [`BFAG_WA_W-1:0] flash_page_addr, // Latched target address
  input  wire                  flash_done,      // Array finished op
  output wire                  cpu_halt,        // Stall the core
  output wire                  area_busy_flag,  // Concurrent area blocked
  input  wire [3:0]            nv_lock_in,      // Stored lock word
  input  wire                  prog_lock_wr,    // External programming
  input  wire [3:0]            prog_lock_data,  // External lock data
  input  wire                  chip_erase,      // Full chip erase
  output wire [3:0]            lock_bits        // Current lock word
);

  // Section decode of a word address
  // Loader section spans loader_start to the top word
  function is_loader;
    input [`BFAG_WA_W-1:0] a;
    input [`BFAG_WA_W-1:0] start;
    begin
      is_loader = (a >= start);
    end
  endfunction

  // Stalling area decode of a word address
  // Fixed split, unlike the fuse-sized loader start
  function is_stall;
    input [`BFAG_WA_W-1:0] a;
    begin
      is_stall = (a >= `BFAG_STALL_START);
    end
  endfunction

  // State, all but rdata_nxt set by the asynchronous reset; lock word and lock_pend_r to ones
  reg  [3:0]            lock_r;      // Lock word, 0 = programmed
  reg                   lock_pend_r; // Lock word not yet loaded
  reg                   busy_r;      // Area busy flag
  reg                   active_r;    // Erase or write in progress
  reg                   op_stall_r;  // Running op hits stalling area
  reg                   vec_ldr_r;   // Irq vectors in loader section
  reg                   fill_r;      // Fill strobe to array
  reg                   erase_r;     // Erase strobe to array
  reg                   write_r;     // Write strobe to array
  reg  [`BFAG_WA_W-1:0] page_r;      // Latched page address
  reg  [7:0]            rdata_r;     // Read data holding register
  reg  [7:0]            rdata_nxt;   // Read data next value

  // Combinational decode terms
  wire [1:0]            app_lock_field;    // App section field
  wire [1:0]            loader_lock_field; // Loader section field
  wire                  app_wdeny;         // App writes barred
  wire                  app_rdeny;         // App cross reads barred
  wire                  ldr_wdeny;         // Loader writes barred
  wire                  ldr_rdeny;         // Loader cross reads barred
  wire                  exec_ldr;          // Running from loader
  wire [`BFAG_WA_W-1:0] load_word;         // Load target word
  wire                  load_ldr;          // Load targets loader
  wire                  tgt_ldr;           // Store targets loader
  wire                  st_ok;             // Store may act at all
  wire                  prog_cmd;          // Erase or write command
  wire                  prog_ok;           // Erase or write passes
  wire                  start_op;          // Erase or write starts
  wire                  rww_set;           // Busy flag set event
  wire                  rww_clr;           // Busy flag clear event
  wire                  lock_set;          // Software lock set

  // Fields kept apart so either can be set alone
  assign app_lock_field    = {lock_r[`BFAG_APP_READ_BIT], lock_r[`BFAG_APP_WRITE_BIT]};
  assign loader_lock_field = {lock_r[`BFAG_LDR_READ_BIT], lock_r[`BFAG_LDR_WRITE_BIT]};

  // One decoder per field, same polarity for both
  bfag_lock_decode u_app_dec (
    .field      (app_lock_field),
    .write_deny (app_wdeny),
    .read_deny  (app_rdeny)
  );

  // Loader field decoder
  bfag_lock_decode u_ldr_dec (
    .field      (loader_lock_field),
    .write_deny (ldr_wdeny),
    .read_deny  (ldr_rdeny)
  );

  // Where code runs and where accesses aim
  // Loads carry byte addresses; the low bit picks the byte
  assign exec_ldr  = is_loader(fetch_addr, loader_start);
  assign load_word = load_addr[`BFAG_BA_W-1:1];
  assign load_ldr  = is_loader(load_word, loader_start);
  assign tgt_ldr   = is_loader(store_addr, loader_start);

  // Stores from the app section and during an op are dropped
  // A store that arrives mid-op is lost, not queued
  assign st_ok    = store_req & exec_ldr & ~active_r;
  assign prog_cmd = (store_cmd == `BFAG_CMD_ERASE) | (store_cmd == `BFAG_CMD_WRITE);

  // General lock modes are not inputs here: stores see only boot locks
  // Fills and lock sets are never refused by the boot locks
  assign prog_ok  = tgt_ldr ? ~ldr_wdeny : ~app_wdeny;
  assign start_op = st_ok & prog_cmd & prog_ok;
  assign lock_set = st_ok & (store_cmd == `BFAG_CMD_LOCK);

  // Busy flag set by an op aimed at the concurrent area
  // Stalling area ops halt the core instead of flagging
  assign rww_set = start_op & ~is_stall(store_addr);

  // Cleared by re-read enable after the op, or by a buffer fill
  // Neither passes while an op runs, st_ok sees to that
  assign rww_clr = st_ok & ((store_cmd == `BFAG_CMD_REREAD) | (store_cmd == `BFAG_CMD_FILL));

  // Halt only while an op on the stalling area runs
  // Registered terms only, so the core sees a clean level
  assign cpu_halt = active_r & op_stall_r;

  // Fetch must wait in a halt or from a blocked area
  // Stalling area code keeps running under a busy flag
  assign fetch_block = cpu_halt | (busy_r & ~is_stall(fetch_addr));

  // Loads: no read in a halt, none of a blocked area,
  // cross-section reads gated by the target's read bit;
  // the general read/write lock has no say here
  assign load_grant = load_req & ~cpu_halt
                    & ~(busy_r & ~is_stall(load_word))
                    & ~(exec_ldr & ~load_ldr & app_rdeny)
                    & ~(~exec_ldr & load_ldr & ldr_rdeny);

  // Irqs muted when vectors sit across a read-locked boundary
  // The core keeps its request pending; this only masks it
  assign irq_allow = irq_req_in
                   & ~(app_rdeny & vec_ldr_r & ~exec_ldr)
                   & ~(ldr_rdeny & ~vec_ldr_r & exec_ldr);

  // Outputs straight from registers
  // No logic after these flip-flops
  assign area_busy_flag  = busy_r;
  assign flash_fill      = fill_r;
  assign flash_erase     = erase_r;
  assign flash_write     = write_r;
  assign flash_page_addr = page_r;
  assign lock_bits       = lock_r;
  assign reg_rdata       = rdata_r;

  // Lock word: loaded after reset, bits only ever programmed
  // Reset alone must not unlock, so the stored word is fetched
  // on the first edge after release rather than under reset
  // Chip erase beats every programming source in one cycle
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_r      <= `BFAG_LOCK_NONE;
      lock_pend_r <= 1'b1;
    end else begin
      lock_pend_r <= 1'b0;
      if (chip_erase) begin
        // Only way back to unprogrammed
        lock_r <= `BFAG_LOCK_NONE;
      end else if (lock_pend_r) begin
        // Pick up the stored word
        lock_r <= nv_lock_in;
      end else if (prog_lock_wr) begin
        // External programming may only program bits
        lock_r <= lock_r & prog_lock_data;
      end else if (lock_set) begin
        // Software may only program bits
        lock_r <= lock_r & store_data[3:0];
      end
    end
  end

  // Op tracking: started by a passing store, ended by the array
  // Stores are refused while active, so start and done never meet
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      active_r   <= 1'b0;
      op_stall_r <= 1'b0;
      page_r     <= {`BFAG_WA_W{1'b0}};
    end else begin
      if (start_op) begin
        // Latch target so the pointer is free again
        active_r   <= 1'b1;
        op_stall_r <= is_stall(store_addr);
        page_r     <= store_addr;
      end else if (flash_done) begin
        // Halt lifts with the array's done
        active_r   <= 1'b0;
        op_stall_r <= 1'b0;
      end
      if (st_ok & (store_cmd == `BFAG_CMD_FILL)) begin
        // Buffer fill also carries its address
        page_r <= store_addr;
      end
    end
  end

  // Array strobes: one-cycle pulses
  // Refused stores leave every strobe low
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      fill_r  <= 1'b0;
      erase_r <= 1'b0;
      write_r <= 1'b0;
    end else begin
      fill_r  <= st_ok & (store_cmd == `BFAG_CMD_FILL);
      erase_r <= start_op & (store_cmd == `BFAG_CMD_ERASE);
      write_r <= start_op & (store_cmd == `BFAG_CMD_WRITE);
    end
  end

  // Busy flag: set beats clear in the same cycle
  // Otherwise a clear beside a new op would hide it
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_r <= 1'b0;
    end else if (rww_set) begin
      busy_r <= 1'b1;
    end else if (rww_clr) begin
      busy_r <= 1'b0;
    end
  end

  // Control register: vector placement
  // Bit 0 high: vectors in the loader section
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      vec_ldr_r <= `BFAG_CTRL_RESET;
    end else if (reg_wr && (reg_addr == `BFAG_REG_CTRL)) begin
      vec_ldr_r <= reg_wdata[`BFAG_CTRL_VEC_BIT];
    end
  end

  // Read mux: unmapped offsets read zero
  // Status is read-only; writes to it are dropped
  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      `BFAG_REG_STATUS: begin
        rdata_nxt[`BFAG_ST_BUSY_BIT]                      = busy_r;
        rdata_nxt[`BFAG_ST_ACTIVE_BIT]                    = active_r;
        rdata_nxt[`BFAG_ST_HALT_BIT]                      = cpu_halt;
        rdata_nxt[`BFAG_ST_LOCK_LSB+3:`BFAG_ST_LOCK_LSB] = lock_r;
      end
      `BFAG_REG_CTRL: begin
        rdata_nxt[`BFAG_CTRL_VEC_BIT] = vec_ldr_r;
      end
      default: begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  // Read data stands one cycle after the strobe only
  // Zero outside the answer cycle keeps the bus quiet
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 8'h00;
    end
  end

endmodule // bfag_guard

// ---- dv/bfag_guard_asserts.sv ----
// Port-level assertions for the flash access guard
`timescale 1ns/1ps
`include "bfag_consts.vh"
module bfag_guard_chk (
  input logic        clk,
  input logic        reset,
  input logic        load_req,
  input logic        load_grant,
  input logic        store_req,
  input logic        chip_erase,
  input logic        flash_fill,
  input logic        flash_erase,
  input logic        flash_write,
  input logic        cpu_halt,
  input logic        fetch_block,
  input logic        area_busy_flag,
  input logic [2:0]  store_cmd,
  input logic [3:0]  lock_bits,
  input logic [12:0] fetch_addr,
  input logic [12:0] loader_start,
  input logic [12:0] store_addr,
  input logic [12:0] flash_page_addr,
  input logic [13:0] load_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire in_ldr = fetch_addr >= loader_start;      // Executing loader code
  wire ld_ldr = load_addr[13:1] >= loader_start; // Load aims at loader
  wire prog   = flash_erase | flash_write;        // Array op launched
  wire any_op = prog | flash_fill;                // Erase, write or fill took effect
  // Erase or write requests only; fills and lock sets never refused by locks
  wire wr_cmd = store_req && (store_cmd == `BFAG_CMD_ERASE || store_cmd == `BFAG_CMD_WRITE);
  AST_HALT_BLOCKS: assert property (cpu_halt |-> fetch_block && !load_grant)
    else $error("core runs during halt");
  AST_STALL_HALT: assert property (prog && flash_page_addr >= 13'h1c00 |-> cpu_halt)
    else $error("stalling area op without halt");
  AST_CONC_RUN: assert property (prog && flash_page_addr < 13'h1c00 |-> !cpu_halt && area_busy_flag)
    else $error("concurrent area op halts or not busy");
  AST_APP_STORE_DEAD: assert property (store_req && !in_ldr |=> !any_op)
    else $error("store from app section acted");
  AST_APP_WLOCK: assert property (wr_cmd && !lock_bits[0] && store_addr < loader_start |=> !prog)
    else $error("app write lock ignored");
  AST_LDR_WLOCK: assert property (wr_cmd && !lock_bits[2] && store_addr >= loader_start |=> !prog)
    else $error("loader write lock ignored");
  AST_APP_RLOCK: assert property (load_req && in_ldr && !ld_ldr && !lock_bits[1] |-> !load_grant)
    else $error("app read lock ignored");
  AST_LDR_RLOCK: assert property (load_req && !in_ldr && ld_ldr && !lock_bits[3] |-> !load_grant)
    else $error("loader read lock ignored");
  AST_LOCK_STICKY: assert property (!chip_erase |=> (lock_bits & ~$past(lock_bits)) == 4'h0)
    else $error("lock bit cleared without chip erase");
  AST_SAME_GRANT: assert property (load_req && !cpu_halt && !area_busy_flag && in_ldr == ld_ldr |-> load_grant)
    else $error("same section load refused");
  // Main scenarios reached
  cover property (flash_erase && cpu_halt);
  cover property (area_busy_flag && !cpu_halt);
  cover property (load_req && !load_grant);
endmodule // bfag_guard_chk

bind bfag_guard bfag_guard_chk u_chk (.clk(clk), .reset(reset), .load_req(load_req), .load_grant(load_grant),
  .store_req(store_req), .chip_erase(chip_erase), .flash_fill(flash_fill), .flash_erase(flash_erase),
  .flash_write(flash_write), .cpu_halt(cpu_halt), .fetch_block(fetch_block), .area_busy_flag(area_busy_flag),
  .store_cmd(store_cmd), .lock_bits(lock_bits), .fetch_addr(fetch_addr), .loader_start(loader_start),
  .store_addr(store_addr), .flash_page_addr(flash_page_addr), .load_addr(load_addr));

// ---- dv/bfag_flash_model.sv ----
// Flash array stand-in: answers erase and write after a set delay
`timescale 1ns/1ps
module bfag_flash_model (
  input  logic       clk,         // System clock
  input  logic       reset,       // Async, active high
  input  logic       flash_erase, // Erase launch pulse
  input  logic       flash_write, // Write launch pulse
  input  logic [5:0] lat,         // Cycles to finish, 1 = prompt
  output logic       flash_done   // One-cycle finish pulse
);
  logic [5:0] cnt_r;  // Remaining cycles
  logic       busy_r; // Operation in progress
  // Count down from launch; a relaunch restarts the count
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 6'h0; busy_r <= 1'b0; flash_done <= 1'b0;
    end else begin
      flash_done <= 1'b0;
      if (flash_erase | flash_write) begin
        busy_r <= 1'b1; cnt_r <= lat;
      end else if (busy_r && cnt_r <= 6'h1) begin
        busy_r <= 1'b0; flash_done <= 1'b1;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 6'h1;
      end
    end
  end
endmodule // bfag_flash_model

// ---- dv/boot_flash_access_guard_tb.sv ----
// Self-checking bench for the flash access guard
`timescale 1ns/1ps
`include "bfag_consts.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR t=%0t got %h want %h", $time, a, b); end end
module boot_flash_access_guard_tb;
  localparam logic [12:0] LS = 13'h1e00, APP = 13'h0100, LDR = 13'h1e40; // Loader start, fetch spots
  logic        clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, irq_req_in = 1, load_req = 0, store_req = 0;
  logic        prog_lock_wr = 0, chip_erase = 0, vec, flash_done, irq_allow, fetch_block, load_grant;
  logic        flash_fill, flash_erase, flash_write, cpu_halt, area_busy_flag;
  logic [2:0]  store_cmd = 0;
  logic [3:0]  reg_addr = 0, prog_lock_data = 0, lock_bits, lk, nv = 4'hf;
  logic [5:0]  lat = 6'h14;
  logic [7:0]  reg_wdata = 0, store_data = 0, reg_rdata, d;
  logic [12:0] fetch_addr = 0, store_addr = 0, flash_page_addr, lw;
  logic [13:0] load_addr = 0;
  int          err_count = 0, n_tests = 0, cyc = 0, seed = 32'hcc8e_9fb1, i, r;
  bfag_guard uut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_addr(fetch_addr), .loader_start(LS), .irq_req_in(irq_req_in),
    .irq_allow(irq_allow), .fetch_block(fetch_block), .load_req(load_req), .load_addr(load_addr),
    .load_grant(load_grant), .store_req(store_req), .store_cmd(store_cmd), .store_addr(store_addr),
    .store_data(store_data), .flash_fill(flash_fill), .flash_erase(flash_erase), .flash_write(flash_write),
    .flash_page_addr(flash_page_addr), .flash_done(flash_done), .cpu_halt(cpu_halt),
    .area_busy_flag(area_busy_flag), .nv_lock_in(nv), .prog_lock_wr(prog_lock_wr),
    .prog_lock_data(prog_lock_data), .chip_erase(chip_erase), .lock_bits(lock_bits));
  bfag_flash_model u_flash (.clk(clk), .reset(reset), .flash_erase(flash_erase), .flash_write(flash_write),
    .lat(lat), .flash_done(flash_done));
  always #5 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin err_count++; tally_and_finish; end
  end
  task tally_and_finish;
    $display("tests %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task done(input string s); $display("test %s done", s); endtask
  // Store op issued while executing at fa; returns in the answer cycle
  task st(input [2:0] c, input [12:0] a, input [7:0] v, input [12:0] fa);
    @(posedge clk); fetch_addr <= fa; store_req <= 1; store_cmd <= c; store_addr <= a; store_data <= v;
    @(posedge clk); store_req <= 0; #1;
  endtask
  task rw(input [3:0] a, input [7:0] v);
    @(posedge clk); reg_wr <= 1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk); reg_wr <= 0;
  endtask
  task rr(input [3:0] a, output [7:0] v);
    @(posedge clk); reg_rd <= 1; reg_addr <= a;
    @(posedge clk); reg_rd <= 0; #1 v = reg_rdata;
  endtask
  task probe(input [12:0] fa, input [13:0] la, input q);
    @(posedge clk); fetch_addr <= fa; load_addr <= la; load_req <= 1; irq_req_in <= q; #1;
  endtask
  // Wait for the array to finish, bounded, then one edge for release
  task wdone;
    for (int k = 0; k < 200 && flash_done !== 1; k++) @(posedge clk) #1;
    @(posedge clk); #1;
  endtask
  task setlk(input [3:0] v);
    @(posedge clk); chip_erase <= 1;
    @(posedge clk); chip_erase <= 0;
    st(`BFAG_CMD_LOCK, 0, {4'h0, v}, LDR);
    @(posedge clk); #1 `CHK(lock_bits, v)
  endtask
  function logic exp_ld(logic [12:0] fa, logic [12:0] w, logic [3:0] k);
    return !((fa >= LS && w < LS && !k[1]) || (fa < LS && w >= LS && !k[3]));
  endfunction
  function logic exp_irq(logic [12:0] fa, logic v, logic [3:0] k);
    return !((fa < LS && !k[1] && v) || (fa >= LS && !k[3] && !v));
  endfunction
  initial begin
    repeat (6) @(posedge clk);
    reset <= 0;
    repeat (2) @(posedge clk);
    #1 `CHK(lock_bits, 4'hf)
    rr(`BFAG_REG_STATUS, d); `CHK(d, 8'hf0)
    done("reset");
    st(`BFAG_CMD_ERASE, 13'h1c10, 0, LDR);
    `CHK({flash_erase, cpu_halt, fetch_block, area_busy_flag}, 4'b1110)
    `CHK(flash_page_addr, 13'h1c10)
    probe(LDR, 14'h3c80, 1); `CHK(load_grant, 1'b0)
    wdone; `CHK(cpu_halt, 1'b0)
    done("stall");
    lat <= 6'h08;
    // Both ways of clearing the busy flag, after an erase and after a write
    for (i = 0; i < 2; i++) begin
      st(i ? `BFAG_CMD_WRITE : `BFAG_CMD_ERASE, APP, 0, LDR);
      `CHK({flash_erase, flash_write, cpu_halt, area_busy_flag}, {i == 0, i == 1, 2'b01})
      probe(LDR, 14'h3c80, 1); `CHK(load_grant, 1'b1)
      probe(LDR, 14'h0200, 1); `CHK(load_grant, 1'b0)
      probe(APP, 14'h0200, 1); `CHK(fetch_block, 1'b1)
      @(posedge clk) load_req <= 0;
      wdone; `CHK(area_busy_flag, 1'b1)
      st(i ? `BFAG_CMD_FILL : `BFAG_CMD_REREAD, APP, 0, LDR);
      `CHK({flash_fill, flash_page_addr}, {i == 1, APP})
      @(posedge clk); #1 `CHK(area_busy_flag, 1'b0)
    end
    done("concurrent");
    st(`BFAG_CMD_ERASE, APP, 0, APP); `CHK({flash_erase, area_busy_flag}, 2'b00)
    setlk(4'ha);
    st(`BFAG_CMD_ERASE, APP, 0, LDR); `CHK(flash_erase, 1'b0)
    st(`BFAG_CMD_WRITE, LDR, 0, LDR); `CHK(flash_write, 1'b0)
    // External programming may only program bits
    @(posedge clk); prog_lock_wr <= 1; prog_lock_data <= 4'hd;
    @(posedge clk); prog_lock_wr <= 0;
    @(posedge clk); #1 `CHK(lock_bits, 4'h8)
    done("write locks");
    // Reset mid-run: the stored word must come back, not all ones
    nv <= lock_bits; reset <= 1;
    repeat (2) @(posedge clk);
    reset <= 0;
    repeat (2) @(posedge clk);
    #1 `CHK(lock_bits, 4'h8)
    rr(`BFAG_REG_STATUS, d); `CHK(d, 8'h80)
    done("reset again");
    for (i = 0; i < 24; i++) begin
      r = $random(seed); lk = $random(seed); vec = r[26];
      setlk(lk); rw(`BFAG_REG_CTRL, {7'h0, vec});
      lw = r[1] ? {4'hf, r[20:12]} : {1'b0, r[23:12]};
      probe(r[0] ? {4'hf, r[8:0]} : {1'b0, r[11:0]}, {lw, r[24]}, r[25]);
      `CHK(load_grant, exp_ld(fetch_addr, lw, lk))
      `CHK(irq_allow, r[25] & exp_irq(fetch_addr, vec, lk))
      @(posedge clk) load_req <= 0;
    end
    rr(`BFAG_REG_CTRL, d); `CHK(d, {7'h0, vec})
    rr(4'h8, d); `CHK(d, 8'h00)
    done("random locks");
    tally_and_finish;
  end
endmodule // boot_flash_access_guard_tb
